// ---- pkg/rotation_params.svh ----
`ifndef ROTATION_PARAMS_SVH
`define ROTATION_PARAMS_SVH

// ****************************************************************
// Sizes of the port set and of the legacy interrupt types.
// ****************************************************************
// Ports 0 to 6 all take inbound messages; the upstream hub link is separate.
`define NUM_PORTS 7
// Four legacy interrupt types, coded A=0, B=1, C=2, D=3.
`define NUM_TYPES 4

// ****************************************************************
// Register map.
// ****************************************************************
// Address bits 7:0 give the offset inside one port's space.
`define REG_OFS_MSB 7
// Address bits 11:8 select the port whose space is reached.
`define REG_PORT_LSB 8
`define REG_PORT_MSB 11
// Rotation control register of every port.
`define ROT_CTRL_OFS 8'h4F
// Combined interrupt vector, answered in every port's space.
`define MERGE_STATE_OFS 8'hE0
// Per-port flags showing which selectors are already written.
`define LOCK_STATE_OFS 8'hE1
// Selector field position and reset value.
`define SEL_LSB 0
`define SEL_MSB 1
`define SEL_RESET 2'h0
// Value read from unmapped offsets and reserved bits.
`define READ_ZERO 8'h00

`endif

// ---- pkg/rotation_pkg.sv ----
package rotation_pkg;
  `include "rotation_params.svh"

  // Two-bit selector and two-bit interrupt type code.
  typedef logic [1:0] sel_t;
  typedef logic [1:0] int_type_t;
  // One bit per interrupt type.
  typedef logic [`NUM_TYPES-1:0] type_vec_t;
  // One bit per port.
  typedef logic [`NUM_PORTS-1:0] port_vec_t;

  // State of the upstream message sender.
  typedef enum logic {
    UP_IDLE = 1'b0,
    UP_SEND = 1'b1
  } up_state_t;
endpackage

// ---- pkg/rotation_if.sv ----
`timescale 1ns/1ps
`include "rotation_params.svh"
// Carries selectors and raw types to the rotator and rotated types back.
interface rotation_if;
  import rotation_pkg::*;
  logic [`NUM_PORTS-1:0][1:0] sel; // Selector of each port.
  logic [`NUM_PORTS-1:0][1:0] in_type; // Received type per port.
  logic [`NUM_PORTS-1:0][1:0] rot_type; // Rotated type per port.

  modport ctrl (output sel, output in_type, input rot_type);
  modport rot (input sel, input in_type, output rot_type);
endinterface

// ---- hdl/intx_rotator.sv ----
`timescale 1ns/1ps
`include "rotation_params.svh"
// Purely combinational barrel rotation of the type code per port.
module intx_rotator
  import rotation_pkg::*;
(
  rotation_if.rot rif // Selectors and types in, rotated types out.
);

  // ****************************************************************
  // Rotation function.
  // ****************************************************************
  // Adding the selector modulo four walks A, B, C, D round the pole.
  function automatic int_type_t rotate(input int_type_t t, input sel_t s);
    rotate = int_type_t'(t + s);
  endfunction

  // Every port has its own copy, so ports never share a mapping.
  genvar p;
  generate
    for (p = 0; p < `NUM_PORTS; p++) begin : g_port
      assign rif.rot_type[p] = rotate(rif.in_type[p], rif.sel[p]);
    end
  endgenerate
endmodule

// ---- hdl/legacy_interrupt_rotation_merge.sv ----
// Function
// - Per-port two-bit selector, writable once
// - Selector rotates interrupt type by its value
// - Selector resets to zero, identity mapping
// - Each port uses only its own selector
// - Only inbound legacy interrupt messages remapped
// - Wired-OR vector changes send upstream messages
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`include "rotation_params.svh"
module legacy_interrupt_rotation_merge
  import rotation_pkg::*;
(
  input wire logic mclk_in, // Core clock, 10 MHz.
  input wire logic rstn_in, // Asynchronous reset, active low.
  input wire logic [11:0] reg_addr_in, // Port in 11:8, offset in 7:0.
  input wire logic [7:0] reg_wdata_in, // Register write data.
  input wire logic reg_wr_in, // Write strobe, one cycle.
  input wire logic reg_rd_in, // Read strobe, one cycle.
  output logic [7:0] reg_rdata_out, // Read data, cycle after strobe.
  input wire logic [6:0] msg_valid_in, // Inbound message per port.
  input wire logic [6:0] msg_intx_in, // Message is a legacy interrupt.
  input wire logic [6:0] msg_assert_in, // 1 assert, 0 deassert.
  input wire logic [13:0] msg_type_in, // Two-bit type per port.
  output logic up_valid_out, // Upstream message pending.
  input wire logic up_ready_in, // Hub link takes the message.
  output logic up_assert_out, // 1 assert, 0 deassert.
  output logic [1:0] up_type_out // Type of the upstream message.
);

  // ****************************************************************
  // Declarations.
  // ****************************************************************
  rotation_if rif (); // Link to the rotator.
  logic [`NUM_PORTS-1:0][1:0] sel; // Selector per port.
  logic [`NUM_PORTS-1:0][1:0] next_sel; // Next selectors.
  port_vec_t locked; // Selector already written once.
  port_vec_t next_locked; // Next lock flags.
  logic [`NUM_PORTS-1:0][3:0] held; // Asserted types per port.
  logic [`NUM_PORTS-1:0][3:0] next_held; // Next asserted types.
  type_vec_t merged; // Wired-OR of all ports.
  type_vec_t sent; // State last reported upstream.
  type_vec_t next_sent; // Next reported state.
  up_state_t up_state; // Sender state.
  up_state_t next_up_state; // Next sender state.
  logic next_up_assert; // Next message polarity.
  int_type_t next_up_type; // Next message type.
  logic [7:0] next_rdata; // Next read data.
  logic [3:0] wr_port; // Port addressed by the bus.

  assign wr_port = reg_addr_in[`REG_PORT_MSB:`REG_PORT_LSB];

  // ****************************************************************
  // Address decode.
  // ****************************************************************
  // True when the address names a given offset of an existing port.
  function automatic logic reg_hit(input logic [11:0] a,
                                   input logic [7:0] ofs);
    reg_hit = (a[`REG_OFS_MSB:0] == ofs) &&
              (a[`REG_PORT_MSB:`REG_PORT_LSB] < 4'(`NUM_PORTS));
  endfunction

  // ****************************************************************
  // Rotator.
  // ****************************************************************
  assign rif.sel = sel;
  assign rif.in_type = msg_type_in;

  intx_rotator u_rot (
    .rif (rif.rot)
  );

  // ****************************************************************
  // Selector registers.
  // ****************************************************************
  // A write reaches a selector only while its lock flag is clear.
  // Firmware must program it before interrupts flow; a late change
  // would strand an asserted type under its old mapping.
  always_comb begin
    next_sel = sel;
    next_locked = locked;
    if (reg_wr_in && reg_hit(reg_addr_in, `ROT_CTRL_OFS) &&
        !locked[wr_port[2:0]]) begin
      next_sel[wr_port[2:0]] = reg_wdata_in[`SEL_MSB:`SEL_LSB];
      next_locked[wr_port[2:0]] = 1'b1;
    end
  end

  // Registers only; reset gives the identity mapping.
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sel <= '0;
      locked <= '0;
    end else begin
      sel <= next_sel;
      locked <= next_locked;
    end
  end

  // ****************************************************************
  // Per-port interrupt tracking.
  // ****************************************************************
  // Each port keeps its own assert bits under the rotated type.
  always_comb begin
    next_held = held;
    for (int p = 0; p < `NUM_PORTS; p++) begin
      if (msg_valid_in[p] && msg_intx_in[p]) begin
        next_held[p][rif.rot_type[p]] = msg_assert_in[p];
      end
    end
  end

  // Tracking registers.
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      held <= '0;
    end else begin
      held <= next_held;
    end
  end

  always_comb begin
    merged = '0;
    for (int p = 0; p < `NUM_PORTS; p++) begin
      merged = merged | held[p];
    end
  end

  // ****************************************************************
  // Upstream message sender.
  // ****************************************************************
  // One message at a time; the lowest changed type goes first, so
  // several changes in one cycle drain in type order.
  always_comb begin
    next_up_state = up_state;
    next_sent = sent;
    next_up_assert = up_assert_out;
    next_up_type = up_type_out;
    if (up_state == UP_IDLE || up_ready_in) begin
      next_up_state = UP_IDLE;
      for (int t = `NUM_TYPES - 1; t >= 0; t--) begin
        if (merged[t] != sent[t]) begin
          next_up_state = UP_SEND;
          next_up_type = int_type_t'(t);
          next_up_assert = merged[t];
        end
      end
      if (next_up_state == UP_SEND) begin
        next_sent[next_up_type] = next_up_assert;
      end
    end
  end

  // Sender registers.
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      up_state <= UP_IDLE;
      sent <= '0;
      up_assert_out <= 1'b0;
      up_type_out <= 2'h0;
    end else begin
      up_state <= next_up_state;
      sent <= next_sent;
      up_assert_out <= next_up_assert;
      up_type_out <= next_up_type;
    end
  end

  assign up_valid_out = (up_state == UP_SEND);

  // ****************************************************************
  // Register read.
  // ****************************************************************
  // Data stand only in the cycle after the strobe, zero otherwise.
  always_comb begin
    next_rdata = `READ_ZERO;
    if (reg_rd_in) begin
      if (reg_hit(reg_addr_in, `ROT_CTRL_OFS)) begin
        next_rdata = {6'h00, sel[wr_port[2:0]]};
      end else if (reg_hit(reg_addr_in, `MERGE_STATE_OFS)) begin
        next_rdata = {4'h0, merged};
      end else if (reg_hit(reg_addr_in, `LOCK_STATE_OFS)) begin
        next_rdata = {1'b0, locked};
      end
    end
  end

  // Read data register.
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      reg_rdata_out <= `READ_ZERO;
    end else begin
      reg_rdata_out <= next_rdata;
    end
  end

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  logic sel_without_write; // Nonzero selector never written.
  always_comb begin
    sel_without_write = 1'b0;
    for (int p = 0; p < `NUM_PORTS; p++) begin
      if (!locked[p] && sel[p] != 2'h0) sel_without_write = 1'b1;
    end
  end

  AST_SEL_WRITE_ONCE: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    (reg_wr_in && reg_hit(reg_addr_in, `ROT_CTRL_OFS) &&
     locked[wr_port[2:0]]) |=> $stable(sel))
    else $error("Locked selector changed by a write.");

  AST_SEL_FIRST_WRITE: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    (reg_wr_in && reg_hit(reg_addr_in, `ROT_CTRL_OFS) &&
     !locked[wr_port[2:0]]) |=>
    sel[$past(wr_port[2:0])] == $past(reg_wdata_in[1:0]))
    else $error("First selector write not taken.");

  AST_SEL_RESET_ZERO: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    !sel_without_write)
    else $error("Unwritten selector is not zero.");

  AST_ROTATE_PORT0: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    (msg_valid_in[0] && msg_intx_in[0] && msg_assert_in[0]) |=>
    held[0][2'($past(msg_type_in[1:0]) + $past(sel[0]))])
    else $error("Port 0 assert not held under rotated type.");

  AST_PORT_INDEPENDENT: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    (msg_valid_in == 7'h02) |=> $stable(held[0]))
    else $error("Port 1 message changed port 0 state.");

  AST_NON_INTX_IGNORED: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    !(|(msg_valid_in & msg_intx_in)) |=> $stable(held))
    else $error("Non-interrupt message changed tracking.");

  AST_UP_REPORT: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    (merged != sent && up_state == UP_IDLE) |=> up_valid_out)
    else $error("Merged change not sent upstream.");

  AST_UP_HOLD: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    (up_valid_out && !up_ready_in) |=>
    up_valid_out && $stable(up_type_out) && $stable(up_assert_out))
    else $error("Upstream message dropped before taken.");

  AST_RSV_ZERO: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    (reg_rd_in && reg_hit(reg_addr_in, `ROT_CTRL_OFS)) |=>
    reg_rdata_out[7:2] == 6'h00)
    else $error("Reserved selector bits not zero.");
endmodule

// ---- dv/hub_link_sink.sv ----
`timescale 1ns/1ps
// ****************************************************************
// Upstream hub link model that takes interrupt messages.
// ****************************************************************
module hub_link_sink (
  input wire logic mclk_in, // Core clock.
  input wire logic rstn_in, // Reset, active low.
  input wire logic stall_in, // Holds off acceptance while high.
  input wire logic up_valid_in, // Message offered by the block.
  input wire logic up_assert_in, // Assert or deassert.
  input wire logic [1:0] up_type_in, // Interrupt type offered.
  output logic up_ready_out, // Accepts the offer at this edge.
  output logic [7:0] got_count_out, // Messages taken since reset.
  output logic got_assert_out, // Kind of the last message.
  output logic [1:0] got_type_out // Type of the last message.
);
  // Ready follows the stall request directly.
  // A slow link is modelled by holding the offer as long as the bench wants.
  assign up_ready_out = ~stall_in;

  // Each message is recorded at the edge where it is handed over.
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      got_count_out <= 8'h00;
      got_assert_out <= 1'b0;
      got_type_out <= 2'h0;
    end else if (up_valid_in && up_ready_out) begin
      got_count_out <= got_count_out + 8'h01;
      got_assert_out <= up_assert_in;
      got_type_out <= up_type_in;
    end
  end
endmodule

// ---- dv/legacy_interrupt_rotation_merge_tb_top.sv ----
`timescale 1ns/1ps
`include "rotation_params.svh"
module legacy_interrupt_rotation_merge_tb_top;
  import rotation_pkg::*;
  // ****************************************************************
  // Stimulus and observed signals.
  // ****************************************************************
  logic mclk, rstn, wr, rd, up_valid, up_ready, up_assert, stall;
  logic [11:0] addr; // Register address.
  logic [7:0] wdata, rdata, got_count, exp_count;
  logic [6:0] msg_valid, msg_intx, msg_assert;
  logic [13:0] msg_type; // Two bits per port.
  logic [1:0] up_type, got_type;
  logic got_assert;
  int errors, checked;

  legacy_interrupt_rotation_merge i_dut (.mclk_in(mclk), .rstn_in(rstn),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_rdata_out(rdata), .msg_valid_in(msg_valid),
    .msg_intx_in(msg_intx), .msg_assert_in(msg_assert),
    .msg_type_in(msg_type), .up_valid_out(up_valid), .up_ready_in(up_ready),
    .up_assert_out(up_assert), .up_type_out(up_type));

  hub_link_sink i_sink (.mclk_in(mclk), .rstn_in(rstn), .stall_in(stall),
    .up_valid_in(up_valid), .up_assert_in(up_assert), .up_type_in(up_type),
    .up_ready_out(up_ready), .got_count_out(got_count),
    .got_assert_out(got_assert), .got_type_out(got_type));

  // A free running clock of 100 ns period.
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // ****************************************************************
  // Shared tasks.
  // ****************************************************************
  // Case equality keeps an unknown from passing as a match.
  task check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task complete_run;
    $display("Comparisons %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // One write cycle, then the strobe drops at the next edge.
  task reg_write(input logic [11:0] a, input logic [7:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe.
  task read_check(input logic [11:0] a, input logic [7:0] exp);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    check(rdata, exp);
  endtask

  // Only the valid bit of the chosen port rises; the rest qualify it.
  task send_msg(input int p, input logic intx, input logic a,
                input logic [1:0] ty);
    @(posedge mclk);
    msg_valid <= 7'h01 << p;
    msg_intx <= {7{intx}};
    msg_assert <= {7{a}};
    msg_type <= {7{ty}};
    @(posedge mclk);
    msg_valid <= 7'h00;
  endtask

  // Bounded wait for the next message taken by the hub link model.
  task expect_msg(input logic [1:0] ty, input logic a);
    int n;
    exp_count = exp_count + 8'h01;
    n = 0;
    while (got_count !== exp_count && n < 30) begin
      @(posedge mclk);
      #1;
      n++;
    end
    // A message that lands on the last try still counts as taken.
    if (got_count !== exp_count) begin
      errors++;
      complete_run;
    end else begin
      check({6'h00, got_type}, {6'h00, ty});
      check({7'h00, got_assert}, {7'h00, a});
    end
  endtask

  // Nothing further may reach the hub link within a few cycles.
  task no_msg;
    repeat (6) @(posedge mclk);
    check(got_count, exp_count);
  endtask

  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial begin
    int p;
    int t;
    rstn = 1'b0;
    {wr, rd, stall} = 3'h0;
    addr = 12'h000;
    wdata = 8'h00;
    {msg_valid, msg_intx, msg_assert} = 21'h000000;
    msg_type = 14'h0000;
    exp_count = 8'h00;
    errors = 0;
    checked = 0;
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    for (p = 0; p < 7; p++) begin
      read_check({4'(p), `ROT_CTRL_OFS}, 8'h00); // reset selector
    end
    read_check({4'h0, `MERGE_STATE_OFS}, 8'h00); // nothing merged
    for (p = 0; p < 7; p++) begin
      reg_write({4'(p), `ROT_CTRL_OFS}, 8'hFC | 8'(p % 4));
    end
    // A second write, even of a new value, must leave the selector alone.
    for (p = 0; p < 7; p++) begin
      reg_write({4'(p), `ROT_CTRL_OFS}, 8'(p % 4) ^ 8'h01);
    end
    for (p = 0; p < 7; p++) begin
      read_check({4'(p), `ROT_CTRL_OFS}, 8'(p % 4)); // write once
    end
    read_check({4'h3, `LOCK_STATE_OFS}, 8'h7F); // all locked
    read_check({4'h7, `ROT_CTRL_OFS}, 8'h00); // no such port
    read_check({4'h1, 8'h10}, 8'h00); // unmapped offset
    // Every port with every type, so all four rotations are seen.
    for (p = 0; p < 7; p++) begin
      for (t = 0; t < 4; t++) begin
        send_msg(p, 1'b1, 1'b1, 2'(t));
        expect_msg(2'(t + p % 4), 1'b1); // rotated assert
        send_msg(p, 1'b1, 1'b0, 2'(t));
        expect_msg(2'(t + p % 4), 1'b0); // rotated deassert
      end
    end
    // Messages of another kind must change nothing.
    send_msg(2, 1'b0, 1'b1, 2'h1);
    no_msg; // other messages
    read_check({4'h2, `MERGE_STATE_OFS}, 8'h00); // vector unchanged
    // Two ports land on type D while the hub link stalls.
    // The stall changes only just after a rising edge, like every input.
    @(posedge mclk);
    stall <= 1'b1;
    send_msg(1, 1'b1, 1'b1, 2'h2);
    send_msg(5, 1'b1, 1'b1, 2'h2);
    read_check({4'h0, `MERGE_STATE_OFS}, 8'h08); // wired-or vector
    check({7'h00, up_valid}, 8'h01); // offer held in stall
    @(posedge mclk);
    stall <= 1'b0;
    expect_msg(2'h3, 1'b1); // one assert
    no_msg; // second source silent
    send_msg(1, 1'b1, 1'b0, 2'h2);
    no_msg; // still held by port five
    send_msg(5, 1'b1, 1'b0, 2'h2);
    expect_msg(2'h3, 1'b0); // last source gone
    complete_run;
  end
endmodule
